//--- hw/sbc_input_sync.sv
// two-flop synchroniser, one per input bit
`timescale 1ns/1ns
module sbc_input_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign sync_out = stage2;

endmodule

//--- hw/sbc_mode_pkg.sv
// shared constants and types for the operating-mode state machine
package sbc_mode_pkg;

  localparam int unsigned CLK_MHZ            = 125;
  localparam int unsigned RESET_DELAY_FIRST_US  = 10;
  localparam int unsigned RESET_DELAY_SECOND_US = 2;
  localparam int unsigned RESET_DELAY_FIRST_CYC  = RESET_DELAY_FIRST_US * CLK_MHZ;
  localparam int unsigned RESET_DELAY_SECOND_CYC = RESET_DELAY_SECOND_US * CLK_MHZ;
  localparam int unsigned LONG_WINDOW_MS     = 200;
  localparam int unsigned LONG_WINDOW_CYC    = LONG_WINDOW_MS * 1000 * CLK_MHZ;
  localparam int unsigned DELAY_W            = 32;

  localparam int unsigned SPI_WORD_W         = 16;
  localparam int unsigned MODE_LSB           = 14;
  localparam int unsigned MODE_W             = 2;

  localparam logic [1:0] MODE_NORMAL     = 2'h0;
  localparam logic [1:0] MODE_SLEEP      = 2'h1;
  localparam logic [1:0] MODE_STOP       = 2'h2;
  localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
  localparam logic [1:0] MODE_RESET_VAL  = 2'h0;

  // gray codes along init -> normal -> stop -> sleep -> restart
  typedef enum logic [2:0] {
    ST_INIT      = 3'h0,
    ST_NORMAL    = 3'h1,
    ST_STOP      = 3'h3,
    ST_SLEEP     = 3'h2,
    ST_RESTART   = 3'h6,
    ST_FAIL_SAFE = 3'h7
  } op_mode_e;

endpackage

//--- hw/sbc_operating_mode_fsm.sv
// operating-mode state machine of the system basis chip
`timescale 1ns/1ns
// Notes on behaviour
// R01 - power-up and soft reset both land in init mode
// R02 - stop mode keeps the main regulator on
// R03 - sleep mode turns the main regulator off
// R04 - wake from sleep/fail-safe or a failure enters restart; controller held in reset
// R05 - restart exits to normal after the chosen reset delay once failure clears
// R06 - critical failures enter fail-safe and turn the main regulator off
// R07 - fail-safe stays until a wake or overtemperature clears
// R08 - development mode allows all modes but stops the watchdog counter; fail-safe is never entered in development mode
// R09 - development mode forces transceiver normal and aux regulator on
// R10 - development mode chosen only from the debug strap during init
// R11 - host accesses arrive as complete 16-bit words
// R12 - host writes the mode field and the device follows it
// R13 - mode field cleared on passing through restart
// R14 - strapped configuration picks restart or fail-safe on watchdog failure
// R15 - soft reset code returns to init, lock-protected bits kept
// R16 - any word in init mode moves to normal
// R17 - wakes are ignored in init mode
// R18 - no watchdog trigger in the long window means failure and restart
module sbc_operating_mode_fsm
  import sbc_mode_pkg::*;
#(
  parameter int unsigned LONG_WINDOW_CYCLES = sbc_mode_pkg::LONG_WINDOW_CYC
) (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              spi_word_valid,
  input  wire logic [sbc_mode_pkg::SPI_WORD_W-1:0] spi_word,
  input  wire logic                              spi_mode_write,
  input  wire logic                              mode_lock,
  input  wire logic                              wd_trigger,
  input  wire logic                              wd_fail,
  input  wire logic                              main_reg_undervoltage,
  input  wire logic                              overtemperature,
  input  wire logic                              debug_strap_pin,
  input  wire logic                              fail_safe_strap_pin,
  input  wire logic                              delay_select,
  input  wire logic                              transceiver_wake,
  input  wire logic                              high_voltage_wake_input,
  input  wire logic                              voltage_sense_input,
  input  wire logic                              gpio_wake,
  output logic                                   main_regulator_output,
  output logic                                   aux_regulator_output,
  output logic                                   mcu_reset_n,
  output logic                                   transceiver_normal,
  output logic                                   watchdog_run,
  output logic                                   development_mode,
  output logic [sbc_mode_pkg::MODE_W-1:0]        mode_field,
  output logic [2:0]                             op_mode
);
  import sbc_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs pass two flops before any logic reads them
  logic [10:0] pins_sync;
  logic        s_wdf;
  logic        s_uv;
  logic        s_ot;
  logic        s_dbg;
  logic        s_fss;
  logic        s_can;
  logic        s_hvw;
  logic        s_vs;
  logic        s_gpio;
  logic        s_dsel;
  logic        s_lock;

  sbc_input_sync #(.WIDTH(11)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({wd_fail, main_reg_undervoltage, overtemperature, debug_strap_pin,
                fail_safe_strap_pin, transceiver_wake, high_voltage_wake_input,
                voltage_sense_input, gpio_wake, delay_select, mode_lock}),
    .sync_out (pins_sync)
  );

  assign {s_wdf, s_uv, s_ot, s_dbg, s_fss, s_can, s_hvw, s_vs, s_gpio, s_dsel, s_lock} =
         pins_sync;

  ////////////////////////////////////////////////////////////////////////////
  // state
  op_mode_e             state;
  op_mode_e             next_state;
  logic [MODE_W-1:0]    mode_reg;
  logic [MODE_W-1:0]    next_mode_reg;
  logic                 dev_mode;
  logic                 next_dev_mode;
  logic                 fs_cfg;
  logic                 next_fs_cfg;
  logic [DELAY_W-1:0]   delay_cnt;
  logic [DELAY_W-1:0]   next_delay_cnt;
  logic [DELAY_W-1:0]   win_cnt;
  logic [DELAY_W-1:0]   next_win_cnt;
  logic                 win_open;
  logic                 next_win_open;
  logic                 win_expired;
  logic                 wake_any;
  logic                 failure;
  logic                 wd_failure;
  logic [MODE_W-1:0]    written_mode;
  logic [DELAY_W-1:0]   delay_limit;

  assign wake_any     = s_can | s_hvw | s_vs | s_gpio;
  assign written_mode = spi_word[MODE_LSB +: MODE_W];                    // R11
  // a stopped counter never times out in development mode
  assign win_expired  = win_open && !dev_mode && (win_cnt >= LONG_WINDOW_CYCLES - 1); // R18
  assign wd_failure   = (s_wdf && !dev_mode) || win_expired;             // R08
  assign failure      = wd_failure | s_uv;
  // delay choice read live from the synced select pin
  assign delay_limit  = s_dsel ? DELAY_W'(RESET_DELAY_SECOND_CYC - 1)
                               : DELAY_W'(RESET_DELAY_FIRST_CYC - 1);     // R05

  always_comb begin
    next_state     = state;
    next_mode_reg  = mode_reg;
    next_dev_mode  = dev_mode;
    next_fs_cfg    = fs_cfg;
    next_delay_cnt = delay_cnt;
    next_win_cnt   = win_cnt;
    next_win_open  = win_open;
    if (win_open && !dev_mode) begin
      next_win_cnt = win_cnt + 32'h0000_0001;                           // R08
    end
    if (win_open && wd_trigger) begin
      next_win_open = 1'b0;
    end
    // expiry is a one-off failure; closing the window lets restart run out
    if (win_expired) begin
      next_win_open = 1'b0;                                              // R18
    end
    case (state)
      ST_INIT: begin
        // straps are caught while init lasts, after reset release
        next_dev_mode = s_dbg;                                           // R10
        next_fs_cfg   = s_fss;                                           // R14
        // wakes have no path out of init
        if (failure) begin                                              // R17
          next_state = ST_RESTART;                                       // R18
        end else if (spi_word_valid) begin
          next_state = ST_NORMAL;                                        // R16
        end
      end
      ST_NORMAL, ST_STOP, ST_SLEEP: begin
        if (failure && (fs_cfg || s_uv) && !dev_mode && wd_failure && fs_cfg) begin
          next_state = ST_FAIL_SAFE;                                     // R06
        end else if (failure) begin
          next_state = ST_RESTART;                                       // R04
        end else if (state == ST_SLEEP && wake_any) begin
          next_state = ST_RESTART;                                       // R04
        end else if (spi_word_valid && spi_mode_write) begin
          case (written_mode)                                            // R12
            MODE_NORMAL: next_state = ST_NORMAL;
            MODE_STOP:   next_state = ST_STOP;
            MODE_SLEEP:  next_state = ST_SLEEP;
            default:     next_state = ST_INIT;                           // R15
          endcase
          if (written_mode == MODE_SOFT_RESET) begin
            // lock keeps the previous field value
            next_mode_reg = s_lock ? mode_reg : MODE_RESET_VAL;          // R15
            next_win_open = 1'b1;
            next_win_cnt  = '0;
          end else begin
            next_mode_reg = written_mode;                                // R12
          end
        end
      end
      ST_RESTART: begin
        next_mode_reg = MODE_RESET_VAL;                                  // R13
        if (failure) begin
          next_delay_cnt = '0;                                           // R05
        end else if (delay_cnt >= delay_limit) begin
          next_state     = ST_NORMAL;                                    // R05
          next_delay_cnt = '0;
          next_win_open  = 1'b1;
          next_win_cnt   = '0;
        end else begin
          next_delay_cnt = delay_cnt + 32'h0000_0001;
        end
      end
      ST_FAIL_SAFE: begin
        if (wake_any || !s_ot) begin
          next_state = ST_RESTART;                                       // R07
        end
      end
      default: next_state = ST_INIT;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= ST_INIT;                                              // R01
      mode_reg  <= MODE_RESET_VAL;
      dev_mode  <= 1'b0;
      fs_cfg    <= 1'b0;
      delay_cnt <= '0;
      win_cnt   <= '0;
      win_open  <= 1'b1;
    end else begin
      state     <= next_state;
      mode_reg  <= next_mode_reg;
      dev_mode  <= next_dev_mode;
      fs_cfg    <= next_fs_cfg;
      delay_cnt <= next_delay_cnt;
      win_cnt   <= next_win_cnt;
      win_open  <= next_win_open;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic next_main;
  logic next_rst_n;

  always_comb begin
    next_main  = !(next_state == ST_SLEEP || next_state == ST_FAIL_SAFE); // R02 R03 R06
    next_rst_n = (next_state != ST_RESTART) && (next_state != ST_INIT);  // R04
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_regulator_output <= 1'b1;
      mcu_reset_n           <= 1'b0;
      aux_regulator_output  <= 1'b0;
      transceiver_normal    <= 1'b0;
      watchdog_run          <= 1'b0;
      development_mode      <= 1'b0;
      mode_field            <= MODE_RESET_VAL;
      op_mode               <= ST_INIT;
    end else begin
      main_regulator_output <= next_main;
      mcu_reset_n           <= next_rst_n;
      aux_regulator_output  <= next_dev_mode;                            // R09
      transceiver_normal    <= next_dev_mode;                            // R09
      watchdog_run          <= !next_dev_mode;                           // R08
      development_mode      <= next_dev_mode;
      mode_field            <= next_mode_reg;
      op_mode               <= next_state;
    end
  end

endmodule

//--- testbench/sbc_host_model.sv
// host model: one 16-bit word plus a watchdog kick per request
`timescale 1ns/1ns
module sbc_host_model (
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic [15:0] word_in,
  input  wire logic        write_in,
  output logic             spi_word_valid,
  output logic [15:0]      spi_word,
  output logic             spi_mode_write,
  output logic             wd_trigger
);
  initial begin
    spi_word_valid = 1'h0;
    spi_word = 16'h0000;
    spi_mode_write = 1'h0;
    wd_trigger = 1'h0;
  end
  // idle lines toggle so stale data never looks valid
  always @(negedge clk_sys) begin
    spi_word_valid <= go;
    spi_word <= go ? word_in : ~spi_word;
    spi_mode_write <= go ? write_in : ~spi_mode_write;
    wd_trigger <= go;
  end
endmodule

//--- testbench/sbc_operating_mode_fsm_properties.sv
// concurrent checks on the operating-mode state machine ports
`timescale 1ns/1ns
module sbc_operating_mode_fsm_properties (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        spi_word_valid,
  input wire logic [15:0] spi_word,
  input wire logic        spi_mode_write,
  input wire logic        main_regulator_output,
  input wire logic        aux_regulator_output,
  input wire logic        mcu_reset_n,
  input wire logic        transceiver_normal,
  input wire logic        watchdog_run,
  input wire logic        development_mode,
  input wire logic [1:0]  mode_field,
  input wire logic [2:0]  op_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic wr;
  assign wr = spi_word_valid && spi_mode_write;
  ////////////////////////////////////////////////////////////////////////////
  AST_INIT_WORD: assert property (op_mode == 3'h0 && spi_word_valid |=> op_mode == 3'h1)
    else $error("init not left on a word");
  AST_SLEEP_WRITE: assert property (op_mode == 3'h1 && wr && spi_word[15:14] == 2'h1
    |=> op_mode == 3'h2) else $error("sleep write not followed");
  AST_SOFT_RESET: assert property (wr && spi_word[15:14] == 2'h3 && op_mode inside
    {3'h1, 3'h2, 3'h3} |=> op_mode == 3'h0) else $error("soft reset missed init");
  AST_STOP_MAIN: assert property (op_mode == 3'h3 |-> main_regulator_output)
    else $error("main off in stop");
  AST_SLEEP_MAIN: assert property (op_mode == 3'h2 |-> !main_regulator_output)
    else $error("main on in sleep");
  AST_FS_MAIN: assert property (op_mode == 3'h7 |-> !main_regulator_output)
    else $error("main on in fail-safe");
  AST_RESTART_RESET: assert property (op_mode == 3'h6 |-> !mcu_reset_n)
    else $error("controller not held in restart");
  AST_RESTART_FIELD: assert property (op_mode == 3'h6 ##1 op_mode == 3'h6
    |-> mode_field == 2'h0) else $error("mode field kept in restart");
  // every reset delay is far above eight cycles
  AST_RESTART_HOLD: assert property (op_mode == 3'h6 && $past(op_mode) != 3'h6
    |=> op_mode == 3'h6 [*8]) else $error("restart left too early");
  AST_DEV_OUT: assert property (development_mode
    |-> aux_regulator_output && transceiver_normal && !watchdog_run) else $error("dev outputs");
  AST_DEV_FROZEN: assert property (op_mode != 3'h0 && $past(op_mode) != 3'h0
    |-> $stable(development_mode)) else $error("dev mode changed outside init");
  cover property (op_mode == 3'h7);
  cover property (op_mode == 3'h6 ##1 op_mode == 3'h1);
  cover property (development_mode && op_mode == 3'h1);
endmodule

//--- testbench/sbc_operating_mode_fsm_tb.sv
// self-checking bench for the operating-mode state machine
`timescale 1ns/1ns
module sbc_operating_mode_fsm_tb;
  import sbc_mode_pkg::*;
  typedef struct packed {logic [1:0] field; op_mode_e mode; logic main;} row_s;
  localparam int unsigned WIN = 50;
  logic clk_sys = 1'h0, rst = 1'h1, go = 1'h0, write_in = 1'h0, wd_fail = 1'h0;
  logic ot = 1'h0, dbg = 1'h0, fss = 1'h0, dsel = 1'h1, lock = 1'h0, uv = 1'h0;
  logic [15:0] word_in = 16'h0000, spi_word;
  logic [3:0]  wk = 4'h0;
  logic        valid, mwr, kick, main_o, aux_o, rst_n_o, trx_o, wdr_o, dev_o;
  logic [1:0]  field;
  logic [2:0]  op_mode;
  int          failures = 0, tests_run = 0;
  row_s        rows [3] = '{'{2'h2, ST_STOP, 1'h1}, '{2'h0, ST_NORMAL, 1'h1},
                            '{2'h1, ST_SLEEP, 1'h0}};
  always #4 clk_sys = ~clk_sys;
  sbc_host_model sbc_host_model_i (.clk_sys(clk_sys), .go(go), .word_in(word_in),
    .write_in(write_in), .spi_word_valid(valid), .spi_word(spi_word),
    .spi_mode_write(mwr), .wd_trigger(kick));
  sbc_operating_mode_fsm #(.LONG_WINDOW_CYCLES(WIN)) sbc_operating_mode_fsm_i (
    .clk_sys(clk_sys), .rst(rst), .spi_word_valid(valid), .spi_word(spi_word),
    .spi_mode_write(mwr), .mode_lock(lock), .wd_trigger(kick), .wd_fail(wd_fail),
    .main_reg_undervoltage(uv), .overtemperature(ot), .debug_strap_pin(dbg),
    .fail_safe_strap_pin(fss), .delay_select(dsel), .transceiver_wake(wk[0]),
    .high_voltage_wake_input(wk[1]), .voltage_sense_input(wk[2]), .gpio_wake(wk[3]),
    .main_regulator_output(main_o), .aux_regulator_output(aux_o), .mcu_reset_n(rst_n_o),
    .transceiver_normal(trx_o), .watchdog_run(wdr_o), .development_mode(dev_o),
    .mode_field(field), .op_mode(op_mode));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_mode(input op_mode_e exp);
    tests_run++;
    if (op_mode !== exp) begin
      failures++;
      $display("CHECK FAILED op_mode expected %0h seen %0h", exp, op_mode);
    end
  endtask
  task automatic chk_val(input string name, input logic [1:0] exp, input logic [1:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic send(input logic [15:0] w, input logic wr);
    @(negedge clk_sys);
    go <= 1'h1;
    word_in <= w;
    write_in <= wr;
    wait_n(1);
    go <= 1'h0;
    wait_n(2);
  endtask
  task automatic do_reset;
    rst <= 1'h1;
    wait_n(5);
    rst <= 1'h0;
    wait_n(2);
  endtask
  task automatic final_report;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wait_n(5);
    chk_mode(ST_INIT);
    chk_val("main", 2'h1, {1'h0, main_o});
    rst <= 1'h0;
    wk <= 4'h1;
    wait_n(6);
    chk_mode(ST_INIT);
    wk <= 4'h0;
    send(16'hffff, 1'h0);
    chk_mode(ST_NORMAL);
    chk_val("rst_n", 2'h1, {1'h0, rst_n_o});
    chk_val("wd_run", 2'h1, {1'h0, wdr_o});
    dbg <= 1'h1;
    wait_n(5);
    chk_val("dev", 2'h0, {1'h0, dev_o});
    dbg <= 1'h0;
    foreach (rows[i]) begin
      send({rows[i].field, 14'h0000}, 1'h1);
      chk_mode(rows[i].mode);
      chk_val("main", {1'h0, rows[i].main}, {1'h0, main_o});
      chk_val("field", rows[i].field, field);
    end
    // each wake source and both reset delays; window reopens after restart
    for (int k = 0; k < 4; k++) begin
      dsel <= k[0];
      if (k > 0) send(16'h4000, 1'h1);
      wk <= 4'h1 << k;
      wait_n(6);
      chk_mode(ST_RESTART);
      chk_val("rst_n", 2'h0, {1'h0, rst_n_o});
      chk_val("field", 2'h0, field);
      wk <= 4'h0;
      wait_n((k[0] ? RESET_DELAY_SECOND_CYC : RESET_DELAY_FIRST_CYC) - 20);
      chk_mode(ST_RESTART);
      wait_n(30);
      chk_mode(ST_NORMAL);
      send(16'h0000, 1'h0);
    end
    send(16'h8000, 1'h1);
    lock <= 1'h1;
    send(16'hc000, 1'h1);
    chk_mode(ST_INIT);
    chk_val("field", 2'h2, field);
    lock <= 1'h0;
    wait_n(WIN + 10);
    chk_mode(ST_RESTART);
    chk_val("field", 2'h0, field);
    fss <= 1'h1;
    ot <= 1'h1;
    do_reset();
    send(16'h0000, 1'h0);
    wd_fail <= 1'h1;
    wait_n(6);
    chk_mode(ST_FAIL_SAFE);
    chk_val("main", 2'h0, {1'h0, main_o});
    wd_fail <= 1'h0;
    send(16'h4000, 1'h1);
    chk_mode(ST_FAIL_SAFE);
    ot <= 1'h0;
    wait_n(6);
    chk_mode(ST_RESTART);
    fss <= 1'h0;
    dbg <= 1'h1;
    do_reset();
    wait_n(WIN + 10);
    chk_mode(ST_INIT);
    send(16'h0000, 1'h0);
    chk_val("dev", 2'h3, {dev_o, aux_o});
    chk_val("trx_wd", 2'h2, {trx_o, wdr_o});
    wd_fail <= 1'h1;
    wait_n(6);
    chk_mode(ST_NORMAL);
    wd_fail <= 1'h0;
    uv <= 1'h1;
    wait_n(6);
    chk_mode(ST_RESTART);
    wait_n(RESET_DELAY_SECOND_CYC + 50);
    chk_mode(ST_RESTART);
    uv <= 1'h0;
    wait_n(RESET_DELAY_SECOND_CYC - 20);
    chk_mode(ST_RESTART);
    wait_n(30);
    chk_mode(ST_NORMAL);
    final_report();
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule
bind sbc_operating_mode_fsm sbc_operating_mode_fsm_properties sbc_operating_mode_fsm_properties_i (
  .clk_sys, .rst, .spi_word_valid, .spi_word, .spi_mode_write, .main_regulator_output,
  .aux_regulator_output, .mcu_reset_n, .transceiver_normal, .watchdog_run,
  .development_mode, .mode_field, .op_mode);
